// ---- cpsc_chk.sv ----
// port assertions for the power-state controller
`timescale 1ns/10ps
`default_nettype none
module cpsc_chk #(
  parameter int NT       = 8,
  parameter int CW       = 2,
  parameter int WAKE_CYC = 100
) (
  input wire logic          clk,
  input wire logic          rst,
  input wire logic          pm_wr,
  input wire logic [CW-1:0] pm_core,
  input wire logic [1:0]    pm_state,
  input wire logic          frame_valid,
  input wire logic [NT-1:0] take_req,
  input wire logic [NT-1:0] pool_member,
  input wire logic [NT-1:0] fetch_en,
  input wire logic [3:0]    snoop_en,
  input wire logic [3:0]    core_clk_en,
  input wire logic [3:0]    core_vdd_ret,
  input wire logic          cl_clk_en,
  input wire logic          cl_vdd_ret,
  input wire logic [NT-1:0] qm_wake,
  input wire logic [NT-1:0] nap_hint,
  input wire logic [NT-1:0] deq_grant
);
  localparam int WA = WAKE_CYC - 2;
  localparam int WB = WAKE_CYC;
  logic [NT-1:0] elig;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign elig = {NT{frame_valid}} & take_req & pool_member & fetch_en;
  chk_lnap_entry:
  assert property (pm_wr && pm_state == 2'h1 && pm_core == '0 &&
    fetch_en[1:0] == 2'h3 && core_clk_en[0] |=>
    fetch_en[1:0] == 2'h0 && snoop_en[0]) else $error("light nap entry");
  chk_dnap_entry:
  assert property (pm_wr && pm_state == 2'h2 && pm_core == '0 &&
    fetch_en[1:0] == 2'h3 && core_clk_en[0] |=>
    !core_clk_en[0] && core_vdd_ret[0]) else $error("deep nap entry");
  chk_clk_off_fetch:
  assert property (!core_clk_en[0] |-> fetch_en[1:0] == 2'h0 && !snoop_en[0])
    else $error("fetch or snoop with clocks off");
  chk_ret_clk_off:
  assert property (core_vdd_ret[0] |-> !core_clk_en[0])
    else $error("retention with clocks on");
  chk_wake_order:
  assert property ($rose(core_clk_en[0]) && $past(cl_clk_en) |->
    ##[WA:WB] $rose(snoop_en[0]) ##1 $rose(fetch_en[0]))
    else $error("deep nap wake order or time");
  chk_cluster_nap:
  assert property (!cl_clk_en |-> cl_vdd_ret && core_clk_en == 4'h0 &&
    snoop_en == 4'h0) else $error("cluster nap outputs");
  chk_qm_wake_sel:
  assert property (qm_wake != '0 |-> $onehot(qm_wake) &&
    (qm_wake & (~$past(pool_member) | fetch_en)) == '0)
    else $error("queue wake target");
  chk_hint_member:
  assert property ((nap_hint & ~$past(pool_member)) == '0)
    else $error("hint to non member");
  chk_grant_lowest:
  assert property (deq_grant == ($past(elig) & (~$past(elig) + 1'b1)))
    else $error("dequeue grant");
endmodule
bind cpsc_top cpsc_chk #(.NT(NT), .CW(CW), .WAKE_CYC(WAKE_CYC)) u_chk (
  .clk, .rst, .pm_wr, .pm_core, .pm_state, .frame_valid, .take_req,
  .pool_member, .fetch_en, .snoop_en, .core_clk_en, .core_vdd_ret,
  .cl_clk_en, .cl_vdd_ret, .qm_wake, .nap_hint, .deq_grant);
`default_nettype wire

// ---- cpsc_consts.svh ----
// constants for the core power-state controller
// Behaviour
// - light nap stops fetch, snooping stays on
// - light nap keeps state, fetch resumes at once
// - deep nap stops fetch and snooping, gates all core clocks
// - deep nap lowers supply into retention, no context lost
// - deep nap wake returns to full operation in about 100 clocks
// - write names target core and state, core then enters it
// - any writer may nap itself or another core
// - core napped by write cannot wake itself
// - wait instruction on a thread enters low power
// - wait exits on trigger, interrupt, doorbell, stash, reservation clear
// - threads wait independently, deep nap only when both wait
// - cluster deep nap after all cores light nap and cache flush
// - queue manager tracks pool membership and channel depth
// - light load hints nap starting at highest numbered thread
// - depth above threshold wakes lowest numbered napping thread
// - any member thread may take a frame from the channel
`ifndef CPSC_CONSTS_SVH
`define CPSC_CONSTS_SVH
`define CPSC_NCORES      4
`define CPSC_THR_PER_CORE 2
`define CPSC_WAKE_CLKS   100
`define CPSC_HINT_DIV    64
`define CPSC_DEPTH_W     16
`define CPSC_CNT_W       12
`define CPSC_CNT_MAX     4095
`define CPSC_PS_RUN      2'h0
`define CPSC_PS_LNAP     2'h1
`define CPSC_PS_DNAP     2'h2
`define CPSC_CNT_ONE     12'h001
`define CPSC_CNT_ZERO    12'h000
`define CPSC_PWR_STEPS   2
`endif

// ---- cpsc_pkg.sv ----
// types for the core power-state controller
package cpsc_pkg;
  typedef enum logic [4:0] {
    CS_RUN  = 5'h01,
    CS_LNAP = 5'h02,
    CS_DNAP = 5'h04,
    CS_WPWR = 5'h08,
    CS_WSNP = 5'h10
  } cpsc_core_st_type;
  typedef enum logic [2:0] {
    CL_ON   = 3'h1,
    CL_DNAP = 3'h2,
    CL_WAKE = 3'h4
  } cpsc_clu_st_type;
endpackage

// ---- cpsc_thr_model.sv ----
// thread-side model that runs wait instructions
`timescale 1ns/10ps
`default_nettype none
module cpsc_thr_model #(
  parameter int NT = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          obey,
  input  wire logic [NT-1:0] cmd,
  input  wire logic [NT-1:0] nap_hint,
  input  wire logic [NT-1:0] fetch_en,
  output logic      [NT-1:0] thr_wait
);
  logic [NT-1:0] hw_r;
  logic [NT-1:0] hw_nxt;
  // hinted thread still fetching waits once
  always_comb begin
    hw_nxt = obey ? (nap_hint & fetch_en & ~hw_r) : '0;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hw_r <= '0;
    end else begin
      hw_r <= hw_nxt;
    end
  end
  assign thr_wait = cmd | hw_r;
endmodule
`default_nettype wire

// ---- cpsc_top.sv ----
// core power-state controller with load-driven nap hints
`include "cpsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module cpsc_top #(
  parameter int NC       = `CPSC_NCORES,
  parameter int WAKE_CYC = `CPSC_WAKE_CLKS,
  parameter int HINT_DIV = `CPSC_HINT_DIV,
  parameter int DW       = `CPSC_DEPTH_W,
  parameter int CW       = (NC > 1) ? $clog2(NC) : 1,
  parameter int NT       = NC * `CPSC_THR_PER_CORE
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          pm_wr,
  input  wire logic [CW-1:0] pm_core,
  input  wire logic [1:0]    pm_state,
  input  wire logic [CW-1:0] pm_src,
  input  wire logic [NT-1:0] thr_wait,
  input  wire logic          ext_trig,
  input  wire logic [NC-1:0] irq,
  input  wire logic [NC-1:0] dbell,
  input  wire logic [NC-1:0] stash,
  input  wire logic [NC-1:0] resv_clr,
  input  wire logic          cl_dnap_req,
  input  wire logic          cl_wake_req,
  input  wire logic          l2_flushed,
  input  wire logic [NT-1:0] pool_member,
  input  wire logic [DW-1:0] pool_depth,
  input  wire logic [DW-1:0] lo_thr,
  input  wire logic [DW-1:0] hi_thr,
  input  wire logic          frame_valid,
  input  wire logic [NT-1:0] take_req,
  output logic      [NT-1:0] fetch_en,
  output logic      [NC-1:0] snoop_en,
  output logic      [NC-1:0] core_clk_en,
  output logic      [NC-1:0] core_vdd_ret,
  output logic               cl_clk_en,
  output logic               cl_vdd_ret,
  output logic      [NT-1:0] nap_hint,
  output logic      [NT-1:0] qm_wake,
  output logic      [NT-1:0] deq_grant
);
  import cpsc_pkg::*;

  // elaboration-time refusal of values the counters cannot serve
  if (NC < 1 || WAKE_CYC < 3 || WAKE_CYC > `CPSC_CNT_MAX || HINT_DIV < 1 ||
      HINT_DIV > `CPSC_CNT_MAX || DW < 1) begin : g_bad_param
    $error("cpsc_top: unsupported parameter values");
  end

  // external trigger pin synchroniser
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_lvl_r;
  logic ext_lvl_nxt;

  always_comb begin
    ext_lvl_nxt = ext_lvl_r;
    if (ext_s2_r == ext_s3_r) begin
      ext_lvl_nxt = ext_s2_r;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_s1_r  <= 1'b0;
      ext_s2_r  <= 1'b0;
      ext_s3_r  <= 1'b0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_s1_r  <= ext_trig;
      ext_s2_r  <= ext_s1_r;
      ext_s3_r  <= ext_s2_r;
      ext_lvl_r <= ext_lvl_nxt;
    end
  end

  // cluster state
  cpsc_clu_st_type         cl_st_r;
  cpsc_clu_st_type         cl_st_nxt;
  logic [`CPSC_CNT_W-1:0]  cl_cnt_r;
  logic [`CPSC_CNT_W-1:0]  cl_cnt_nxt;
  logic [NC-1:0]           core_lnap;
  logic [NT-1:0]           wait_all;
  logic [NT-1:0]           fetch_nxt;
  logic [NC-1:0]           snoop_nxt;
  logic [NC-1:0]           clk_nxt;
  logic [NC-1:0]           ret_nxt;
  logic                    cl_on_nxt;

  always_comb begin
    cl_st_nxt  = cl_st_r;
    cl_cnt_nxt = cl_cnt_r;
    unique case (cl_st_r)
      CL_ON: begin
        if (cl_dnap_req && (&core_lnap) && l2_flushed) begin
          cl_st_nxt = CL_DNAP;
        end
      end
      CL_DNAP: begin
        if (cl_wake_req) begin
          cl_st_nxt  = CL_WAKE;
          cl_cnt_nxt = `CPSC_CNT_ZERO;
        end
      end
      CL_WAKE: begin
        cl_cnt_nxt = cl_cnt_r + `CPSC_CNT_ONE;
        if (cl_cnt_r == `CPSC_CNT_W'(WAKE_CYC - 1)) begin
          cl_st_nxt = CL_ON;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cl_st_r  <= CL_ON;
      cl_cnt_r <= `CPSC_CNT_ZERO;
    end else begin
      cl_st_r  <= cl_st_nxt;
      cl_cnt_r <= cl_cnt_nxt;
    end
  end

  assign cl_on_nxt = (cl_st_nxt == CL_ON);

  // per-core power state
  for (genvar c = 0; c < NC; c++) begin : g_core
    cpsc_core_st_type        st_r;
    cpsc_core_st_type        st_nxt;
    logic                    src_wait_r;
    logic                    src_wait_nxt;
    logic [1:0]              wait_r;
    logic [1:0]              wait_nxt;
    logic [`CPSC_CNT_W-1:0]  cnt_r;
    logic [`CPSC_CNT_W-1:0]  cnt_nxt;
    logic                    trig;
    logic                    hit;
    logic                    other;

    always_comb begin
      trig = ext_lvl_r | irq[c] | dbell[c] | stash[c] | resv_clr[c] |
             qm_wake[2*c] | qm_wake[2*c+1];
      hit   = pm_wr && (pm_core == CW'(c));
      other = (pm_src != CW'(c));
      st_nxt       = st_r;
      src_wait_nxt = src_wait_r;
      cnt_nxt      = cnt_r;
      // thread waits; a new wait wins over a same-cycle wake, except in the cycle the core leaves deep nap, which clears both waits
      wait_nxt = (trig ? 2'h0 : wait_r) | thr_wait[2*c +: 2];
      unique case (st_r)
        CS_RUN: begin
          if (hit && pm_state == `CPSC_PS_LNAP) begin
            st_nxt       = CS_LNAP;
            src_wait_nxt = 1'b0;
          end else if (hit && pm_state == `CPSC_PS_DNAP) begin
            st_nxt       = CS_DNAP;
            src_wait_nxt = 1'b0;
          end else if (&wait_nxt) begin
            st_nxt       = CS_DNAP;
            src_wait_nxt = 1'b1;
          end
        end
        CS_LNAP: begin
          if (cl_st_r != CL_ON) begin
            st_nxt = CS_LNAP;
          end else if (hit && pm_state == `CPSC_PS_DNAP) begin
            st_nxt       = CS_DNAP;
            src_wait_nxt = 1'b0;
          end else if (!src_wait_r && hit && other &&
                       pm_state == `CPSC_PS_RUN) begin
            st_nxt = CS_RUN;
          end else if (src_wait_r && trig) begin
            st_nxt = CS_RUN;
          end
        end
        CS_DNAP: begin
          if ((!src_wait_r && hit && other && pm_state == `CPSC_PS_RUN) ||
              (src_wait_r && trig)) begin
            st_nxt   = CS_WPWR;
            cnt_nxt  = `CPSC_CNT_ZERO;
            wait_nxt = 2'h0;
          end
        end
        CS_WPWR: begin
          cnt_nxt = cnt_r + `CPSC_CNT_ONE;
          if (cnt_r == `CPSC_CNT_W'(WAKE_CYC - `CPSC_PWR_STEPS)) begin
            st_nxt = CS_WSNP;
          end
        end
        CS_WSNP: begin
          st_nxt = CS_RUN;
        end
      endcase
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        st_r       <= CS_RUN;
        src_wait_r <= 1'b0;
        wait_r     <= 2'h0;
        cnt_r      <= `CPSC_CNT_ZERO;
      end else begin
        st_r       <= st_nxt;
        src_wait_r <= src_wait_nxt;
        wait_r     <= wait_nxt;
        cnt_r      <= cnt_nxt;
      end
    end

    assign core_lnap[c]        = (st_r == CS_LNAP);
    assign wait_all[2*c +: 2]  = wait_r;
    assign fetch_nxt[2*c]      = (st_nxt == CS_RUN) && !wait_nxt[0];
    assign fetch_nxt[2*c+1]    = (st_nxt == CS_RUN) && !wait_nxt[1];
    assign snoop_nxt[c]        = cl_on_nxt &&
                                 (st_nxt == CS_RUN || st_nxt == CS_LNAP ||
                                  st_nxt == CS_WSNP);
    assign clk_nxt[c]          = cl_on_nxt && (st_nxt != CS_DNAP);
    assign ret_nxt[c]          = !cl_on_nxt || (st_nxt == CS_DNAP);
  end

  // queue manager load-driven nap scheme
  logic [`CPSC_CNT_W-1:0]  div_r;
  logic [`CPSC_CNT_W-1:0]  div_nxt;
  logic                    tick;
  logic [NT-1:0]           hint_nxt;
  logic [NT-1:0]           wake_nxt;
  logic [NT-1:0]           grant_nxt;
  logic [NT-1:0]           hint_sel;
  logic [NT-1:0]           wake_sel;

  always_comb begin
    tick    = (div_r == `CPSC_CNT_W'(HINT_DIV - 1));
    div_nxt = tick ? `CPSC_CNT_ZERO : div_r + `CPSC_CNT_ONE;
    hint_sel  = '0;
    wake_sel  = '0;
    grant_nxt = '0;
    // ascending scan keeps the highest candidate
    for (int t = 0; t < NT; t++) begin
      if (pool_member[t] && !nap_hint[t] && fetch_en[t]) begin
        hint_sel    = '0;
        hint_sel[t] = 1'b1;
      end
    end
    // descending scan keeps the lowest candidate
    for (int t = NT - 1; t >= 0; t--) begin
      if (pool_member[t] && wait_all[t]) begin
        wake_sel    = '0;
        wake_sel[t] = 1'b1;
      end
      if (frame_valid && pool_member[t] && take_req[t] && fetch_en[t]) begin
        grant_nxt    = '0;
        grant_nxt[t] = 1'b1;
      end
    end
    hint_nxt = nap_hint & pool_member;
    wake_nxt = '0;
    if (tick && pool_depth > hi_thr) begin
      wake_nxt = wake_sel;
      hint_nxt = hint_nxt & ~wake_sel;
    end else if (tick && pool_depth < lo_thr) begin
      hint_nxt = hint_nxt | hint_sel;
    end
    if (pool_depth >= lo_thr) begin
      hint_nxt = hint_nxt & wait_all;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_r <= `CPSC_CNT_ZERO;
    end else begin
      div_r <= div_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_en     <= '1;
      snoop_en     <= '1;
      core_clk_en  <= '1;
      core_vdd_ret <= '0;
      cl_clk_en    <= 1'b1;
      cl_vdd_ret   <= 1'b0;
      nap_hint     <= '0;
      qm_wake      <= '0;
      deq_grant    <= '0;
    end else begin
      fetch_en     <= fetch_nxt;
      snoop_en     <= snoop_nxt;
      core_clk_en  <= clk_nxt;
      core_vdd_ret <= ret_nxt;
      cl_clk_en    <= cl_on_nxt;
      cl_vdd_ret   <= !cl_on_nxt;
      nap_hint     <= hint_nxt;
      qm_wake      <= wake_nxt;
      deq_grant    <= grant_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- cpsc_top_test.sv ----
// self-checking bench for the power-state controller
`timescale 1ns/10ps
`default_nettype none
module cpsc_top_test;
  localparam int WC = 4;
  logic        clk, rst, pm_wr, cl_dnap_req, cl_wake_req, l2_flushed;
  logic        frame_valid, obey, cl_clk_en, cl_vdd_ret;
  logic [1:0]  pm_core, pm_state, pm_src;
  logic [4:0]  trg;
  logic [3:0]  snoop_en, core_clk_en, core_vdd_ret;
  logic [7:0]  cmd, thr_wait, pool_member, take_req, fetch_en;
  logic [7:0]  nap_hint, qm_wake, deq_grant;
  logic [15:0] pool_depth, lo_thr, hi_thr;
  int          n_errors, compares, n;
  cpsc_top #(.WAKE_CYC(WC), .HINT_DIV(2)) uut (.clk, .rst, .pm_wr,
    .pm_core, .pm_state, .pm_src, .thr_wait, .ext_trig(trg[4]),
    .irq({3'h0, trg[0]}), .dbell({3'h0, trg[1]}), .stash({3'h0, trg[2]}),
    .resv_clr({3'h0, trg[3]}), .cl_dnap_req, .cl_wake_req, .l2_flushed,
    .pool_member, .pool_depth, .lo_thr, .hi_thr, .frame_valid, .take_req,
    .fetch_en, .snoop_en, .core_clk_en, .core_vdd_ret, .cl_clk_en,
    .cl_vdd_ret, .nap_hint, .qm_wake, .deq_grant);
  cpsc_thr_model #(.NT(8)) thr (.clk, .rst, .obey, .cmd, .nap_hint,
    .fetch_en, .thr_wait);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(int c);
    repeat (c) @(posedge clk);
    #1;
    n++;
    if (n > 300) begin
      chk("wait bound", 16'h0, 16'h1);
      give_verdict();
    end
  endtask
  task automatic pmw(logic [1:0] c, logic [1:0] s, logic [1:0] src);
    @(posedge clk);
    pm_wr <= 1'b1;
    {pm_core, pm_state, pm_src} <= {c, s, src};
    @(posedge clk);
    pm_wr <= 1'b0;
    #1;
  endtask
  task automatic t_deq;
    @(posedge clk);
    {frame_valid, take_req} <= {1'b1, 8'h0C};
    @(posedge clk);
    frame_valid <= 1'b0;
    #1;
    chk("grant", 16'h04, deq_grant);
    @(posedge clk) pool_member <= 8'hC0;
    $display("dequeue test done");
  endtask
  task automatic t_nap;
    pmw(2'h1, 2'h1, 2'h0);
    chk("light nap", 16'h01, {fetch_en[3:2], snoop_en[1]});
    pmw(2'h1, 2'h0, 2'h1);
    chk("self wake", 16'h0, fetch_en[3:2]);
    pmw(2'h1, 2'h0, 2'h2);
    chk("light wake", 16'h3, fetch_en[3:2]);
    pmw(2'h0, 2'h2, 2'h0);
    chk("deep nap", 16'h1, {core_clk_en[0], snoop_en[0], fetch_en[1:0],
      core_vdd_ret[0]});
    @(posedge clk) trg <= 5'h01;
    step(2);
    @(posedge clk) trg <= 5'h00;
    #1;
    chk("trigger", 16'h0, core_clk_en[0]);
    pmw(2'h0, 2'h0, 2'h3);
    chk("wake clk", 16'h2, {core_clk_en[0], snoop_en[0]});
    for (n = 0; fetch_en[1:0] !== 2'h3; ) step(1);
    chk("wake time", 16'h1, 16'(n >= WC - 2 && n <= WC));
    $display("nap test done");
  endtask
  task automatic t_wait(int kind);
    @(posedge clk) cmd <= 8'h01;
    @(posedge clk) cmd <= 8'h00;
    #1;
    chk("one wait", 16'h6, {core_clk_en[0], fetch_en[1:0]});
    @(posedge clk) cmd <= 8'h02;
    @(posedge clk) cmd <= 8'h00;
    #1;
    chk("both wait", 16'h0, {core_clk_en[0], fetch_en[1:0]});
    @(posedge clk) trg <= 5'(1 << kind);
    for (n = 0; fetch_en[1:0] !== 2'h3; ) step(1);
    chk("wait wake", 16'h1, 16'(n <= WC + 6));
    @(posedge clk) trg <= 5'h00;
    step(6);
    $display("wait test %0d done", kind);
  endtask
  task automatic t_cluster;
    for (int i = 0; i < 4; i++) pmw(2'(i), 2'h1, 2'(i + 1));
    @(posedge clk) {l2_flushed, cl_dnap_req} <= 2'h3;
    @(posedge clk) {l2_flushed, cl_dnap_req} <= 2'h0;
    #1;
    chk("cluster nap", 16'h01, {core_clk_en, snoop_en, cl_clk_en,
      cl_vdd_ret});
    @(posedge clk) cl_wake_req <= 1'b1;
    @(posedge clk) cl_wake_req <= 1'b0;
    for (n = 0; cl_clk_en !== 1'b1; ) step(1);
    chk("cluster wake", 16'hF00, {snoop_en, fetch_en});
    for (int i = 0; i < 4; i++) pmw(2'(i), 2'h0, 2'(i + 1));
    for (n = 0; fetch_en !== 8'hFF; ) step(1);
    $display("cluster test done");
  endtask
  task automatic t_qm;
    @(posedge clk) {obey, pool_depth} <= {1'b1, 16'h0};
    for (n = 0; nap_hint === 8'h00; ) step(1);
    chk("first hint", 16'h80, nap_hint);
    for (n = 0; fetch_en[7:6] !== 2'h0; ) step(1);
    @(posedge clk) {obey, pool_depth} <= {1'b0, 16'h14};
    for (n = 0; qm_wake === 8'h00; ) step(1);
    chk("queue wake", 16'h40, qm_wake);
    for (n = 0; fetch_en !== 8'hFF; ) step(1);
    $display("queue test done");
  endtask
  initial begin
    {rst, pm_wr, cl_dnap_req, cl_wake_req, l2_flushed} = 5'h10;
    {frame_valid, obey, pm_core, pm_state, pm_src, trg} = '0;
    {cmd, take_req, pool_member} = {16'h0, 8'hFF};
    {pool_depth, lo_thr, hi_thr} = {16'h6, 16'h4, 16'h8};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_deq();
    t_nap();
    for (int i = 0; i < 5; i++) t_wait(i);
    t_cluster();
    t_qm();
    give_verdict();
  end
endmodule
`default_nettype wire
